// [design/sgoc_defines.vh]
// Shared constants for the switchgear object controller
// Assumes a 250 MHz system clock and a millisecond tick derived from it
`ifndef SGOC_DEFINES_VH
`define SGOC_DEFINES_VH
`define SGOC_CLK_MHZ        250
`define SGOC_TICK_US        1000
`define SGOC_TICK_CYC       (`SGOC_CLK_MHZ * `SGOC_TICK_US)
`define SGOC_POS_INTER      2'b00
`define SGOC_POS_OPEN       2'b01
`define SGOC_POS_CLOSED     2'b10
`define SGOC_POS_BAD        2'b11
`define SGOC_CMD_NONE       2'b00
`define SGOC_CMD_OPEN       2'b01
`define SGOC_CMD_CLOSE      2'b10
`define SGOC_EV_OPEN_REQ    0
`define SGOC_EV_CLOSE_REQ   1
`define SGOC_EV_OPEN_FAIL   2
`define SGOC_EV_CLOSE_FAIL  3
`define SGOC_EV_BANK        4
`define SGOC_EV_W           5
`define SGOC_REC_DEPTH      12
`define SGOC_BANKS          8
`define SGOC_BANK_USED_RST  8'h01
`define SGOC_ST_IDLE        2'b00
`define SGOC_ST_PULSE       2'b01
`define SGOC_ST_WAIT        2'b10
`endif

// [design/sgoc_top.v]
// One switchgear object with command gating, pulsed coils, statistics,
// record store, masked events, latched indications and parameter bank choice.
// Assumes all inputs synchronous to clk_sys and command requests as one-cycle pulses.
`include "sgoc_defines.vh"

module sgoc_top #(
	parameter TICK_CYC = `SGOC_TICK_CYC,
	parameter CNT_W    = 16,
	parameter TMR_W    = 16,
	parameter BLK_W    = 8,
	parameter IND_W    = 4
) (
	input  wire                   clk_sys,
	input  wire                   rstn,
	input  wire                   obj_enable,
	input  wire                   pos_open_in,
	input  wire                   pos_closed_in,
	input  wire                   cart_in,
	input  wire                   cart_out,
	input  wire                   remote_sel,
	input  wire                   local_open_req,
	input  wire                   local_close_req,
	input  wire                   bus_open_req,
	input  wire                   bus_close_req,
	input  wire                   app_open_req,
	input  wire                   app_close_req,
	input  wire                   use_synchro,
	input  wire                   synchro_ok,
	input  wire                   use_ready,
	input  wire                   obj_ready,
	input  wire [BLK_W-1:0]       block_src,
	input  wire [BLK_W-1:0]       block_en,
	input  wire [TMR_W-1:0]       max_pulse_ms,
	input  wire [TMR_W-1:0]       term_timeout_ms,
	input  wire [TMR_W-1:0]       traverse_ms,
	input  wire                   clear_stats,
	input  wire                   clear_records,
	input  wire [`SGOC_EV_W-1:0]  event_mask,
	input  wire [IND_W-1:0]       ind_latched_cfg,
	input  wire                   latch_clear,
	input  wire                   bank_enable,
	input  wire [7:0]             bank_used,
	input  wire [7:0]             bank_local_req,
	input  wire                   force_en,
	input  wire [2:0]             force_bank,
	input  wire                   force_req,
	input  wire                   remote_bank_en,
	input  wire [2:0]             bus_bank,
	input  wire                   bus_bank_req,
	input  wire [3:0]             rec_rd_idx,
	output reg                    open_out,
	output reg                    close_out,
	output reg  [1:0]             position,
	output reg  [CNT_W-1:0]       open_req_cnt,
	output reg  [CNT_W-1:0]       close_req_cnt,
	output reg  [CNT_W-1:0]       open_fail_cnt,
	output reg  [CNT_W-1:0]       close_fail_cnt,
	output reg  [IND_W-1:0]       ind_out,
	output reg  [2:0]             active_bank,
	output reg  [`SGOC_EV_W-1:0]  event_strobe,
	output reg  [3:0]             rec_count,
	output reg  [TMR_W+2:0]       rec_rd_data
);

	function [2:0] sgoc_lowest;
		input [7:0] v;
		integer i;
		begin
			sgoc_lowest = 3'd0;
			for (i = 7; i >= 0; i = i - 1) begin
				if (v[i]) begin
					sgoc_lowest = i[2:0];
				end
			end
		end
	endfunction

	reg  [31:0]          tick_cnt;
	reg                  tick;
	reg  [1:0]           state;
	reg  [1:0]           cmd;
	reg  [TMR_W-1:0]     pulse_ms;
	reg  [TMR_W-1:0]     wait_ms;
	reg  [TMR_W-1:0]     trav_ms;
	reg  [1:0]           raw_q;
	reg  [1:0]           start_pos;
	reg  [TMR_W+2:0]     rec_mem [0:`SGOC_REC_DEPTH-1];
	reg  [3:0]           rec_wr;
	reg  [IND_W-1:0]     ind_hold;
	reg  [2:0]           next_bank;
	wire                 raw_open;
	wire                 raw_closed;
	wire [1:0]           raw_pos;
	wire                 blocked;
	wire                 perm_close;
	wire                 req_open;
	wire                 req_close;
	wire                 go_open;
	wire                 go_close;
	wire                 moved;
	wire                 fail_now;
	wire                 done_ok;
	wire [IND_W-1:0]     ind_src;
	wire [7:0]           bank_pick;
	integer              k;

	assign raw_open   = pos_open_in | cart_out;
	assign raw_closed = pos_closed_in | cart_in;
	assign raw_pos    = {raw_closed, raw_open};
	assign blocked    = |(block_src & block_en);
	assign perm_close = (~use_synchro | synchro_ok) & (~use_ready | obj_ready);
	assign req_open   = app_open_req | (remote_sel ? bus_open_req : local_open_req);
	assign req_close  = app_close_req | (remote_sel ? bus_close_req : local_close_req);
	assign go_open    = obj_enable & ~blocked & (state == `SGOC_ST_IDLE) & req_open;
	assign go_close   = obj_enable & ~blocked & (state == `SGOC_ST_IDLE) & ~req_open &
	                    req_close & perm_close;
	assign moved      = (cmd == `SGOC_CMD_OPEN) ? (raw_pos == `SGOC_POS_OPEN) :
	                    (raw_pos == `SGOC_POS_CLOSED);
	assign done_ok    = (state != `SGOC_ST_IDLE) & moved;
	assign fail_now   = (state != `SGOC_ST_IDLE) & ~moved & tick &
	                    (wait_ms + 1'b1 >= term_timeout_ms);
	assign ind_src    = {position == `SGOC_POS_BAD, position == `SGOC_POS_INTER,
	                     position == `SGOC_POS_CLOSED, position == `SGOC_POS_OPEN};

	assign bank_pick  = bank_local_req & bank_used;

	always @(posedge clk_sys) begin
		if (!rstn) begin
			tick_cnt <= 32'h00000000;
			tick     <= 1'b0;
		end else if (tick_cnt >= TICK_CYC - 1) begin
			tick_cnt <= 32'h00000000;
			tick     <= 1'b1;
		end else begin
			tick_cnt <= tick_cnt + 32'h00000001;
			tick     <= 1'b0;
		end
	end

	// Position decode with traverse filter
	always @(posedge clk_sys) begin
		if (!rstn) begin
			raw_q    <= `SGOC_POS_INTER;
			position <= `SGOC_POS_INTER;
			trav_ms  <= {TMR_W{1'b0}};
		end else begin
			raw_q <= raw_pos;
			if (raw_pos == `SGOC_POS_BAD) begin
				position <= `SGOC_POS_BAD;
				trav_ms  <= {TMR_W{1'b0}};
			end else if (raw_pos != `SGOC_POS_INTER) begin
				position <= raw_pos;
				trav_ms  <= {TMR_W{1'b0}};
			end else if (raw_q != `SGOC_POS_INTER) begin
				trav_ms <= {TMR_W{1'b0}};
			end else if (tick && trav_ms < traverse_ms) begin
				trav_ms <= trav_ms + 1'b1;
			end else if (trav_ms >= traverse_ms) begin
				position <= `SGOC_POS_INTER;
			end
		end
	end

	// Command sequencer
	always @(posedge clk_sys) begin
		if (!rstn) begin
			state     <= `SGOC_ST_IDLE;
			cmd       <= `SGOC_CMD_NONE;
			pulse_ms  <= {TMR_W{1'b0}};
			wait_ms   <= {TMR_W{1'b0}};
			open_out  <= 1'b0;
			close_out <= 1'b0;
			start_pos <= `SGOC_POS_INTER;
		end else begin
			case (state)
				`SGOC_ST_IDLE: begin
					pulse_ms <= {TMR_W{1'b0}};
					wait_ms  <= {TMR_W{1'b0}};
					if (go_open) begin
						cmd       <= `SGOC_CMD_OPEN;
						open_out  <= 1'b1;
						start_pos <= raw_pos;
						state     <= `SGOC_ST_PULSE;
					end else if (go_close) begin
						cmd       <= `SGOC_CMD_CLOSE;
						close_out <= 1'b1;
						start_pos <= raw_pos;
						state     <= `SGOC_ST_PULSE;
					end
				end
				`SGOC_ST_PULSE: begin
					if (tick) begin
						pulse_ms <= pulse_ms + 1'b1;
						wait_ms  <= wait_ms + 1'b1;
					end
					if (done_ok || fail_now || (tick && pulse_ms + 1'b1 >= max_pulse_ms)) begin
						open_out  <= 1'b0;
						close_out <= 1'b0;
						state     <= (done_ok || fail_now) ? `SGOC_ST_IDLE : `SGOC_ST_WAIT;
					end
				end
				`SGOC_ST_WAIT: begin
					if (tick) begin
						wait_ms <= wait_ms + 1'b1;
					end
					if (done_ok || fail_now) begin
						state <= `SGOC_ST_IDLE;
					end
				end
				default: begin
					state     <= `SGOC_ST_IDLE;
					open_out  <= 1'b0;
					close_out <= 1'b0;
				end
			endcase
		end
	end

	// Statistics counters
	always @(posedge clk_sys) begin
		if (!rstn || clear_stats) begin
			open_req_cnt   <= {CNT_W{1'b0}};
			close_req_cnt  <= {CNT_W{1'b0}};
			open_fail_cnt  <= {CNT_W{1'b0}};
			close_fail_cnt <= {CNT_W{1'b0}};
		end else begin
			if (go_open) begin
				open_req_cnt <= open_req_cnt + 1'b1;
			end
			if (go_close) begin
				close_req_cnt <= close_req_cnt + 1'b1;
			end
			if (fail_now && cmd == `SGOC_CMD_OPEN) begin
				open_fail_cnt <= open_fail_cnt + 1'b1;
			end
			if (fail_now && cmd == `SGOC_CMD_CLOSE) begin
				close_fail_cnt <= close_fail_cnt + 1'b1;
			end
		end
	end

	// record store
	// Entry: failed flag, command type, operating time in ms
	always @(posedge clk_sys) begin
		if (!rstn || clear_records) begin
			rec_wr    <= 4'h0;
			rec_count <= 4'h0;
			for (k = 0; k < `SGOC_REC_DEPTH; k = k + 1) begin
				rec_mem[k] <= {(TMR_W+3){1'b0}};
			end
		end else if (done_ok || fail_now) begin
			rec_mem[rec_wr] <= {fail_now, cmd, wait_ms};
			rec_wr <= (rec_wr == `SGOC_REC_DEPTH - 1) ? 4'h0 : rec_wr + 4'h1;
			if (rec_count != `SGOC_REC_DEPTH) begin
				rec_count <= rec_count + 4'h1;
			end
		end
	end

	always @(posedge clk_sys) begin
		if (!rstn) begin
			rec_rd_data <= {(TMR_W+3){1'b0}};
		end else if (rec_rd_idx < `SGOC_REC_DEPTH) begin
			rec_rd_data <= rec_mem[rec_rd_idx];
		end else begin
			rec_rd_data <= {(TMR_W+3){1'b0}};
		end
	end

	always @(posedge clk_sys) begin
		if (!rstn) begin
			ind_hold <= {IND_W{1'b0}};
			ind_out  <= {IND_W{1'b0}};
		end else begin
			ind_hold <= ind_src | (ind_hold & ~({IND_W{latch_clear}} & ~ind_src));
			ind_out  <= (ind_src & ~ind_latched_cfg) |
			            ((ind_src | ind_hold) & ind_latched_cfg & {IND_W{obj_enable}});
		end
	end

	// Parameter bank selection; the change event follows the real next bank
	always @* begin
		next_bank = active_bank;
		if (bank_enable) begin
			if (force_en && force_req && bank_used[force_bank]) begin
				next_bank = force_bank;
			end else if (remote_bank_en && bus_bank_req && bank_used[bus_bank]) begin
				next_bank = bus_bank;
			end else if (|bank_pick) begin
				next_bank = sgoc_lowest(bank_pick);
			end
		end
	end

	always @(posedge clk_sys) begin
		if (!rstn) begin
			active_bank <= 3'd0;
		end else begin
			active_bank <= next_bank;
		end
	end

	always @(posedge clk_sys) begin
		if (!rstn) begin
			event_strobe <= {`SGOC_EV_W{1'b0}};
		end else begin
			event_strobe[`SGOC_EV_OPEN_REQ]   <= go_open & event_mask[`SGOC_EV_OPEN_REQ];
			event_strobe[`SGOC_EV_CLOSE_REQ]  <= go_close & event_mask[`SGOC_EV_CLOSE_REQ];
			event_strobe[`SGOC_EV_OPEN_FAIL]  <= fail_now & (cmd == `SGOC_CMD_OPEN) &
			                                     event_mask[`SGOC_EV_OPEN_FAIL];
			event_strobe[`SGOC_EV_CLOSE_FAIL] <= fail_now & (cmd == `SGOC_CMD_CLOSE) &
			                                     event_mask[`SGOC_EV_CLOSE_FAIL];
			event_strobe[`SGOC_EV_BANK]       <= (next_bank != active_bank) & event_mask[`SGOC_EV_BANK];
		end
	end

endmodule

// [verif/sgoc_breaker_model.sv]
// Breaker model: contacts follow the coils after DLY cycles of travel
// stuck jams the mechanism with both contacts released
module sgoc_breaker_model #(parameter int DLY = 20) (
	input wire logic  clk_sys,
	input wire logic  open_out,
	input wire logic  close_out,
	input wire logic  stuck,
	output logic      pos_open_in,
	output logic      pos_closed_in
);
	timeunit 1ns;
	timeprecision 1ps;
	logic closed = 1'b1;
	logic hung = 1'b0;
	int cnt = 0;
	wire coil = open_out || close_out;
	wire trav = coil && (closed != close_out);
	always @(posedge clk_sys) begin
		cnt <= coil ? cnt + 1 : 0;
		if (!stuck && trav && cnt == DLY)
			closed <= close_out;
		hung <= stuck && (hung || coil);
	end
	// Both contacts open while travelling or jammed
	assign pos_closed_in = closed && !trav && !hung;
	assign pos_open_in = !closed && !trav && !hung;
endmodule

// [verif/sgoc_checker.sv]
// Port assertions for the switchgear object controller
// Bound to sgoc_top; one clock domain, synchronous active-low reset
module sgoc_checker #(parameter int CNT_W = 16) (
	input wire logic             clk_sys,
	input wire logic             rstn,
	input wire logic             obj_enable,
	input wire logic             pos_open_in,
	input wire logic             pos_closed_in,
	input wire logic             cart_in,
	input wire logic             cart_out,
	input wire logic             remote_sel,
	input wire logic             local_open_req,
	input wire logic             bus_open_req,
	input wire logic             app_open_req,
	input wire logic             use_synchro,
	input wire logic             synchro_ok,
	input wire logic             use_ready,
	input wire logic             obj_ready,
	input wire logic [7:0]       block_src,
	input wire logic [7:0]       block_en,
	input wire logic             clear_stats,
	input wire logic [4:0]       event_mask,
	input wire logic             open_out,
	input wire logic             close_out,
	input wire logic [1:0]       position,
	input wire logic [CNT_W-1:0] open_req_cnt,
	input wire logic [4:0]       event_strobe
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	sequence s_open_go;
		$rose(open_out);
	endsequence
	sequence s_any_go;
		$rose(open_out) || $rose(close_out);
	endsequence
	a_bad_pos: assert property ((pos_open_in || cart_out) && (pos_closed_in || cart_in)
		|=> position == 2'b11) else $error("faulty position not shown");
	a_enable_gate: assert property (s_any_go |-> $past(obj_enable))
		else $error("command while disabled");
	a_access_side: assert property (s_open_go |-> $past(app_open_req ||
		(remote_sel ? bus_open_req : local_open_req))) else $error("open from wrong side");
	a_close_permit: assert property ($rose(close_out) |-> $past((!use_synchro || synchro_ok)
		&& (!use_ready || obj_ready))) else $error("close without permissive");
	a_block_gate: assert property (s_any_go |-> $past((block_src & block_en) == 8'h00))
		else $error("command while blocked");
	a_req_count: assert property (s_open_go and !$past(clear_stats)
		|-> open_req_cnt == $past(open_req_cnt) + 1'b1) else $error("open count not stepped");
	a_stats_clear: assert property (clear_stats |=> open_req_cnt == '0)
		else $error("counter not cleared");
	a_pulse_cut: assert property ($rose(pos_open_in) && open_out && !pos_closed_in && !cart_in
		|=> !open_out) else $error("open pulse not cut short");
	a_event_mask: assert property ((event_strobe & ~$past(event_mask)) == 5'h00)
		else $error("masked event emitted");
	a_one_command: assert property (open_out |=> !$rose(close_out))
		else $error("second command while busy");
endmodule

bind sgoc_top sgoc_checker #(.CNT_W(CNT_W)) u_chk (.*);

// [verif/sgoc_test.sv]
// Self-checking bench for sgoc_top driving a breaker model
// Millisecond tick shortened to 10 clocks; inputs change by NBA at posedge
module sgoc_test;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int S = 400;
	logic clk_sys, rstn, obj_enable, stuck, remote_sel, use_synchro, synchro_ok;
	logic use_ready, obj_ready, cart_in, cart_out, clear_stats, clear_records;
	logic local_open_req, local_close_req, bus_open_req, bus_close_req;
	logic app_open_req, app_close_req, latch_clear, bank_enable, force_en, force_req;
	logic remote_bank_en, bus_bank_req, pos_open_in, pos_closed_in, open_out, close_out;
	logic [7:0] block_src, block_en, bank_used, bank_local_req;
	logic [15:0] max_pulse_ms, term_timeout_ms, traverse_ms;
	logic [15:0] open_req_cnt, close_req_cnt, open_fail_cnt, close_fail_cnt;
	logic [4:0] event_mask, event_strobe;
	logic [3:0] ind_latched_cfg, ind_out, rec_rd_idx, rec_count;
	logic [2:0] force_bank, bus_bank, active_bank;
	logic [1:0] position, bq;
	logic [5:0] rq;
	logic [18:0] rec_rd_data;
	int err_total = 0;
	int total_checks = 0;
	logic [4:0] ev_seen;
	always @(posedge clk_sys) ev_seen <= rstn ? (ev_seen | event_strobe) : 5'h00;
	assign {app_close_req, app_open_req, bus_close_req} = rq[5:3];
	assign {bus_open_req, local_close_req, local_open_req} = rq[2:0];
	assign {force_req, bus_bank_req} = bq;
	sgoc_top #(.TICK_CYC(10)) dut (.*);
	sgoc_breaker_model u_brk (.*);
	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end
	task chk(input string n, input logic [18:0] e, input logic [18:0] g);
		total_checks++;
		if (g !== e) begin
			err_total++;
			$display("unexpected %s expected %h seen %h", n, e, g);
		end
	endtask
	task req(input logic [5:0] r);
		@(posedge clk_sys) rq <= r;
		@(posedge clk_sys) rq <= 6'h00;
		repeat (S) @(posedge clk_sys);
	endtask
	task bk(input logic [1:0] b, input logic [2:0] e);
		@(posedge clk_sys) bq <= b;
		@(posedge clk_sys) bq <= 2'h0;
		repeat (4) @(posedge clk_sys);
		chk("bank", e, active_bank);
	endtask
	task final_report;
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk_sys);
		err_total++;
		final_report();
	end
	initial begin
		{rstn, obj_enable, stuck, remote_sel, use_synchro, synchro_ok, use_ready} = '0;
		{obj_ready, cart_in, cart_out, clear_stats, clear_records, latch_clear} = '0;
		{bank_enable, force_en, remote_bank_en, bq, rq, force_bank, bus_bank} = '0;
		{block_src, block_en, bank_local_req, event_mask, ind_latched_cfg, rec_rd_idx} = '0;
		bank_used = 8'h01;
		max_pulse_ms = 16'h0014;
		term_timeout_ms = 16'h001e;
		traverse_ms = 16'h0005;
		repeat (20) @(posedge clk_sys);
		rstn <= 1'b1;
		req(6'h10);
		chk("open count", 0, open_req_cnt);
		chk("bank", 0, active_bank);
		$display("test disabled done");
		obj_enable <= 1'b1;
		event_mask <= 5'h1f;
		req(6'h08);
		chk("close count", 0, close_req_cnt);
		req(6'h01);
		chk("open count", 1, open_req_cnt);
		chk("position", 2'b01, position);
		remote_sel <= 1'b1;
		use_synchro <= 1'b1;
		req(6'h02);
		req(6'h08);
		chk("close count", 0, close_req_cnt);
		synchro_ok <= 1'b1;
		req(6'h08);
		chk("close count", 1, close_req_cnt);
		chk("position", 2'b10, position);
		$display("test access done");
		block_src <= 8'h80;
		block_en <= 8'h80;
		req(6'h10);
		chk("open count", 1, open_req_cnt);
		block_en <= 8'h00;
		stuck <= 1'b1;
		req(6'h10);
		chk("open count", 2, open_req_cnt);
		chk("open fails", 1, open_fail_cnt);
		chk("close fails", 0, close_fail_cnt);
		chk("position", 2'b00, position);
		chk("records", 3, rec_count);
		chk("events", 5'h07, ev_seen);
		rec_rd_idx <= 4'h2;
		repeat (2) @(posedge clk_sys);
		chk("record kind", 3'b101, rec_rd_data[18:16]);
		$display("test failure done");
		stuck <= 1'b0;
		clear_stats <= 1'b1;
		clear_records <= 1'b1;
		@(posedge clk_sys) {clear_stats, clear_records} <= 2'b00;
		repeat (2) @(posedge clk_sys);
		chk("counts", 0, open_req_cnt | close_req_cnt | open_fail_cnt);
		chk("records", 0, rec_count);
		ind_latched_cfg <= 4'h8;
		cart_out <= 1'b1;
		repeat (3) @(posedge clk_sys);
		chk("position", 2'b11, position);
		chk("indication", 4'h8, ind_out);
		cart_out <= 1'b0;
		repeat (3) @(posedge clk_sys);
		chk("indication", 4'ha, ind_out);
		latch_clear <= 1'b1;
		@(posedge clk_sys) latch_clear <= 1'b0;
		repeat (3) @(posedge clk_sys);
		chk("indication", 4'h2, ind_out);
		$display("test status done");
		bank_enable <= 1'b1;
		bank_used <= 8'h4c;
		bank_local_req <= 8'h0b;
		bk(2'h0, 3'h3);
		bank_local_req <= 8'h0f;
		bk(2'h0, 3'h2);
		bank_local_req <= 8'h00;
		bus_bank <= 3'h3;
		bk(2'h1, 3'h2);
		remote_bank_en <= 1'b1;
		bk(2'h1, 3'h3);
		force_bank <= 3'h6;
		bk(2'h2, 3'h3);
		force_en <= 1'b1;
		bk(2'h2, 3'h6);
		chk("events", 5'h17, ev_seen);
		$display("test banks done");
		final_report();
	end
endmodule
